// *** dv/bas_codec_model.sv ***
`timescale 1ns/1ps
module bas_codec_model (
    input wire logic gen_en,
    input wire logic sck,
    input wire logic ws,
    input wire logic sdo,
    input wire logic [31:0] snd,
    output logic sck_m,
    output logic ws_m,
    output logic sdi,
    output logic trail_one,
    output logic [31:0] got,
    output logic [6:0] bits,
    output int nfr
);
    logic ws_q = 1'b0;
    logic [5:0] cnt = 6'h3f;
    logic [6:0] rises = 7'h00;
    logic [3:0] nfall = 4'h0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] left = 16'h0000;
    logic [15:0] nx;
    initial begin
        sck_m = 1'b0;
        ws_m = 1'b0;
        sdi = 1'b0;
        trail_one = 1'b0;
        got = 32'h0;
        bits = 7'h00;
        nfr = 0;
    end
    // ********
    // Clock source in slave mode, still when idle
    // ********
    always #200 sck_m = gen_en ? ~sck_m : 1'b0;
    always @(negedge sck_m) begin
        nfall <= nfall + 4'h1;
        if (nfall == 4'hf) begin
            ws_m <= ~ws_m;
        end
    end
    always @(posedge sck) begin
        nx = (cnt < 6'h10) ? {sh[14:0], sdo} : sh;
        sh <= nx;
        cnt <= (cnt < 6'h10) ? cnt + 6'h01 : cnt;
        rises <= rises + 7'h01;
        ws_q <= ws;
        if (cnt >= 6'h10 && sdo === 1'b1) begin
            trail_one <= 1'b1;
        end
        if (ws !== ws_q) begin
            cnt <= 6'h00;
            if (ws) begin
                left <= nx;
            end else begin
                got <= {left, nx};
                bits <= rises;
                rises <= 7'h01;
                nfr <= nfr + 1;
            end
        end
    end
    always @(negedge sck) begin
        sdi <= (cnt < 6'h10) ? snd[(ws_q ? 15 : 31) - cnt] : ~sdi;
    end
endmodule

// *** dv/tb_bas_audio_port.sv ***
`timescale 1ns/1ps
module tb_bas_audio_port;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic master_mode = 1'b1;
    logic frame_50 = 1'b0;
    logic [11:0] div_num = bas_pkg::DIV_NUM_32;
    logic [11:0] div_den = bas_pkg::DIV_DEN_32;
    logic [31:0] tx_data = 32'h0;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b1;
    logic gen_en = 1'b0;
    logic [31:0] snd = 32'h5a3c_c3a5;
    logic sck_out, sck_oe, ws_out, ws_oe, sdo, sdo_oe, sdi, sck_m, ws_m;
    logic tx_ready, rx_valid, tx_underrun, rx_overflow, trail_one;
    logic [31:0] rx_data, got;
    logic [6:0] bits;
    logic seen_ur = 1'b0;
    logic seen_ov = 1'b0;
    logic sck_q = 1'b0;
    int nfr;
    int num_errors = 0;
    int cmp_count = 0;
    int run = 0;
    int ph_lo = 99;
    int per_hi = 0;
    int ph_last = 0;
    int ntog = 0;
    wire logic sck = sck_oe ? sck_out : sck_m;
    wire logic ws = ws_oe ? ws_out : ws_m;
    bas_audio_port bas_audio_port_i (.clock, .rst_n, .master_mode, .frame_50, .div_num,
        .div_den, .sck_in(sck), .sck_out, .sck_oe, .ws_in(ws), .ws_out, .ws_oe, .sdo,
        .sdo_oe, .sdi, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
        .tx_underrun, .rx_overflow);
    bas_codec_model bas_codec_model_i (.gen_en, .sck, .ws, .sdo, .snd, .sck_m, .ws_m,
        .sdi, .trail_one, .got, .bits, .nfr);
    // ********
    // Clock and monitors
    // ********
    always #20 clock = ~clock;
    always @(posedge clock) begin
        sck_q <= sck_out;
        run <= run + 1;
        seen_ur <= rst_n & (seen_ur | tx_underrun);
        seen_ov <= rst_n & (seen_ov | rx_overflow);
        if (!rst_n) begin
            ntog <= 0;
            ph_last <= 0;
            ph_lo <= 99;
            per_hi <= 0;
        end else if (sck_oe && sck_out != sck_q) begin
            run <= 1;
            ntog <= ntog + 1;
            ph_last <= run;
            if (ntog >= 1 && run < ph_lo) ph_lo <= run;
            if (ntog >= 2 && run + ph_last > per_hi) per_hi <= run + ph_last;
        end
    end
    // ********
    // Tasks
    // ********
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic m, input logic f);
        rst_n <= 1'b0;
        master_mode <= m;
        frame_50 <= f;
        div_num <= f ? bas_pkg::DIV_NUM_50 : bas_pkg::DIV_NUM_32;
        div_den <= f ? bas_pkg::DIV_DEN_50 : bas_pkg::DIV_DEN_32;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        check("sck_oe", sck_oe, m);
        check("ws_oe", ws_oe, m);
        check("sdo_oe", sdo_oe, 1'b1);
    endtask
    task automatic push(input logic [31:0] d, input logic last);
        int i;
        tx_data <= d;
        tx_valid <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (tx_ready !== 1'b1 && i < 2000);
        if (last) tx_valid <= 1'b0;
        if (tx_ready !== 1'b1) begin
            check("tx_ready", tx_ready, 1'b1);
            conclude();
        end
    endtask
    task automatic frame(input logic [31:0] exp, input logic seek);
        int i;
        int n;
        n = nfr;
        for (i = 0; i < 6000 && (nfr == n || (seek && got !== exp)); i++) begin
            @(posedge clock);
        end
        check("frame", got, exp);
        if (i >= 6000) begin
            check("timeout", 32'h1, 32'h0);
            conclude();
        end
    endtask
    task automatic drain();
        check("rx_valid", rx_valid, 1'b1);
        check("rx_data", rx_data, snd);
        rx_ready <= 1'b1;
        repeat (5) @(posedge clock);
        check("rx_empty", rx_valid, 1'b0);
    endtask
    task automatic t_master32();
        do_reset(1'b1, 1'b0);
        push(32'ha1b2_c3d4, 1'b0);
        push(32'h8001_7ffe, 1'b1);
        repeat (2) @(posedge clock);
        check("tx_full", tx_ready, 1'b0);
        frame(32'ha1b2_c3d4, 1'b1);
        rx_ready <= 1'b0;
        frame(32'h8001_7ffe, 1'b0);
        frame(32'h0, 1'b0);
        frame(32'h0, 1'b0);
        check("bits", bits, 7'h20);
        check("underrun", seen_ur, 1'b1);
        check("overflow", seen_ov, 1'b1);
        check("phase", ph_lo * 100 >= per_hi * 35 && per_hi > 0, 1'b1);
        drain();
        $display("master 32 test done");
    endtask
    task automatic t_master50();
        do_reset(1'b1, 1'b1);
        push(32'h0f0f_f0f0, 1'b1);
        frame(32'h0f0f_f0f0, 1'b1);
        frame(32'h0, 1'b0);
        check("bits", bits, 7'h32);
        check("phase", ph_lo * 100 >= per_hi * 35 && per_hi > 0, 1'b1);
        check("trail", trail_one, 1'b0);
        $display("master 50 test done");
    endtask
    task automatic t_slave();
        do_reset(1'b0, 1'b0);
        push(32'h1357_9bdf, 1'b1);
        gen_en <= 1'b1;
        frame(32'h1357_9bdf, 1'b1);
        rx_ready <= 1'b0;
        frame(32'h0, 1'b0);
        frame(32'h0, 1'b0);
        check("bits", bits, 7'h20);
        drain();
        gen_en <= 1'b0;
        $display("slave test done");
    endtask
    initial begin
        t_master32();
        t_master50();
        t_slave();
        conclude();
    end
endmodule

// *** src/bas_audio_port.sv ***
`timescale 1ns/1ps
module bas_audio_port (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic master_mode,
    input wire logic frame_50,
    input wire logic [11:0] div_num,
    input wire logic [11:0] div_den,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic ws_in,
    output logic ws_out,
    output logic ws_oe,
    output logic sdo,
    output logic sdo_oe,
    input wire logic sdi,
    input wire logic [31:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [31:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic tx_underrun,
    output logic rx_overflow
);
    // ************************************************************
    // Master clock generation
    // ************************************************************
    logic [11:0] acc;
    logic [12:0] acc_sum;
    logic tick;
    logic mfall;
    logic [4:0] half_cnt;
    logic [4:0] half_len;

    assign acc_sum = {1'b0, acc} + {1'b0, div_num};
    assign tick = master_mode && (acc_sum >= {1'b0, div_den});
    assign mfall = tick && sck_out;
    assign half_len = frame_50 ? bas_pkg::HALF_SLOTS_50 : bas_pkg::HALF_SLOTS_32;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc <= bas_pkg::ACC_RESET;
        end else if (tick) begin
            acc <= 12'(acc_sum - {1'b0, div_den});
        end else if (master_mode) begin
            acc <= acc_sum[11:0];
        end else begin
            acc <= bas_pkg::ACC_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sck_out <= 1'b0;
        end else if (tick) begin
            sck_out <= !sck_out;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            half_cnt <= bas_pkg::CNT_RESET;
            ws_out <= 1'b0;
        end else if (mfall) begin
            if (half_cnt >= half_len - 5'h01) begin
                half_cnt <= bas_pkg::CNT_RESET;
                ws_out <= !ws_out;
            end else begin
                half_cnt <= half_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sck_oe <= 1'b0;
            ws_oe <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sck_oe <= master_mode;
            ws_oe <= master_mode;
            sdo_oe <= 1'b1;
        end
    end

    // ************************************************************
    // Edge detection on the active bit clock
    // ************************************************************
    logic sck_now;
    logic ws_now;
    logic sck_prev;
    logic rise;
    logic fall;

    assign sck_now = master_mode ? sck_out : sck_in;
    assign ws_now = master_mode ? ws_out : ws_in;
    assign rise = sck_now && !sck_prev;
    assign fall = !sck_now && sck_prev;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_now;
        end
    end

    // ************************************************************
    // Word framing
    // ************************************************************
    logic ws_s;
    logic start_pend;
    logic chan_pend;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ws_s <= 1'b0;
            start_pend <= 1'b0;
            chan_pend <= 1'b0;
        end else if (rise) begin
            ws_s <= ws_now;
            if (ws_now != ws_s) begin
                start_pend <= 1'b1;
                chan_pend <= ws_now;
            end
        end else if (fall) begin
            start_pend <= 1'b0;
        end
    end

    // ************************************************************
    // Transmit path
    // ************************************************************
    logic [31:0] txb_data;
    logic txb_valid;
    logic txb_pop;
    logic [15:0] tx_sh;
    logic [15:0] right_hold;
    logic [15:0] load_word;
    logic [4:0] tx_cnt;

    assign txb_pop = fall && start_pend && !chan_pend;
    assign load_word = chan_pend ? right_hold : (txb_valid ? txb_data[31:16] : 16'h0000);

    bas_skid_buffer #(.WIDTH(32)) u_tx_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(txb_data),
        .out_valid(txb_valid),
        .out_ready(txb_pop)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            right_hold <= bas_pkg::WORD_RESET;
            tx_underrun <= 1'b0;
        end else begin
            tx_underrun <= txb_pop && !txb_valid;
            if (txb_pop) begin
                right_hold <= txb_valid ? txb_data[15:0] : 16'h0000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sdo <= 1'b0;
            tx_sh <= bas_pkg::WORD_RESET;
            tx_cnt <= bas_pkg::IDLE_COUNT;
        end else if (fall) begin
            if (start_pend) begin
                sdo <= load_word[15];
                tx_sh <= {load_word[14:0], 1'b0};
                tx_cnt <= 5'h01;
            end else if (tx_cnt < bas_pkg::WORD_SLOTS) begin
                sdo <= tx_sh[15];
                tx_sh <= {tx_sh[14:0], 1'b0};
                tx_cnt <= tx_cnt + 5'h01;
            end else begin
                sdo <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Receive path
    // ************************************************************
    logic [15:0] rx_sh;
    logic [15:0] left_hold;
    logic [4:0] rx_cnt;
    logic rx_chan;
    logic rxb_push;
    logic rxb_ready;
    logic [31:0] rxb_data;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_sh <= bas_pkg::WORD_RESET;
            left_hold <= bas_pkg::WORD_RESET;
            rx_cnt <= bas_pkg::IDLE_COUNT;
            rx_chan <= 1'b0;
            rxb_push <= 1'b0;
            rxb_data <= '0;
            rx_overflow <= 1'b0;
        end else begin
            rxb_push <= 1'b0;
            rx_overflow <= rxb_push && !rxb_ready;
            if (fall && start_pend) begin
                rx_cnt <= bas_pkg::CNT_RESET;
                rx_chan <= chan_pend;
            end else if (rise && rx_cnt < bas_pkg::WORD_SLOTS) begin
                rx_sh <= {rx_sh[14:0], sdi};
                rx_cnt <= rx_cnt + 5'h01;
                if (rx_cnt == bas_pkg::WORD_SLOTS - 5'h01) begin
                    if (rx_chan) begin
                        rxb_data <= {left_hold, rx_sh[14:0], sdi};
                        rxb_push <= 1'b1;
                    end else begin
                        left_hold <= {rx_sh[14:0], sdi};
                    end
                end
            end
        end
    end

    bas_skid_buffer #(.WIDTH(32)) u_rx_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_data(rxb_data),
        .in_valid(rxb_push),
        .in_ready(rxb_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    logic [4:0] phase_cnt;

    always_ff @(posedge clock) begin
        if (!rst_n || tick) begin
            phase_cnt <= 5'h01;
        end else if (phase_cnt != 5'h1f) begin
            phase_cnt <= phase_cnt + 5'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    pin_dir_a: assert property ($past(rst_n) |-> sck_oe == $past(master_mode)
        && ws_oe == $past(master_mode))
        else $error("Clock pin direction wrong for mode");
    sdo_drive_a: assert property ($past(rst_n) |-> sdo_oe)
        else $error("Serial data output not driven");
    ws_edge_a: assert property (master_mode && $changed(ws_out) |-> $past(mfall))
        else $error("Word select moved away from clock fall");
    rx_cap_a: assert property (rise && rx_cnt < bas_pkg::WORD_SLOTS
        |=> rx_sh[0] == $past(sdi))
        else $error("Input bit not captured on rising edge");
    sdo_fall_a: assert property (##1 sdo != $past(sdo) |-> $past(fall))
        else $error("Serial data changed away from falling edge");
    word_len_a: assert property (tx_cnt <= bas_pkg::WORD_SLOTS)
        else $error("Transmit word exceeded sixteen bits");
    tail_zero_a: assert property (fall && !start_pend && tx_cnt == bas_pkg::WORD_SLOTS
        |=> !sdo)
        else $error("Trailing slot not zero");
    msb_start_a: assert property (rise && ws_now != ws_s |=> start_pend)
        else $error("Word start not armed after select edge");
    half_len_a: assert property (master_mode && !$changed(frame_50)
        |-> half_cnt < half_len)
        else $error("Master half frame too long");
    div_range_a: assert property (master_mode && !$changed(div_den) && acc < div_den
        |=> acc < div_den)
        else $error("Divider accumulator out of range");
    phase_min_a: assert property (tick && $past(tick, 1) == 1'b0 && $stable(div_num)
        && (div_den == bas_pkg::DIV_DEN_32 && div_num == bas_pkg::DIV_NUM_32
        || div_den == bas_pkg::DIV_DEN_50 && div_num == bas_pkg::DIV_NUM_50)
        |-> phase_cnt >= bas_pkg::MIN_PHASE_CYC)
        else $error("Master clock phase too short");
endmodule

// *** src/bas_pkg.sv ***
package bas_pkg;
    // ************************************************************
    // Word and frame shape
    // ************************************************************
    localparam int WORD_BITS = 16;
    localparam logic [4:0] HALF_SLOTS_32 = 5'h10;
    localparam logic [4:0] HALF_SLOTS_50 = 5'h19;
    localparam logic [4:0] WORD_SLOTS = 5'h10;
    localparam logic [4:0] IDLE_COUNT = 5'h10;

    // ************************************************************
    // Clock and divider
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int FRAME_RATE_HZ = 48000;
    localparam int SLAVE_MAX_BCLK_KHZ = 3072;
    localparam int SLAVE_MIN_PERIOD_CYC = (1000000 / SLAVE_MAX_BCLK_KHZ) / CLK_PERIOD_NS;
    localparam int DIV_BITS = 12;
    localparam logic [11:0] DIV_NUM_32 = 12'h180;
    localparam logic [11:0] DIV_DEN_32 = 12'hc35;
    localparam logic [11:0] DIV_NUM_50 = 12'h018;
    localparam logic [11:0] DIV_DEN_50 = 12'h07d;
    localparam logic [4:0] MIN_PHASE_CYC = 5'h05;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [11:0] ACC_RESET = 12'h000;
    localparam logic [4:0] CNT_RESET = 5'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// *** src/bas_skid_buffer.sv ***
`timescale 1ns/1ps
module bas_skid_buffer #(
    parameter int WIDTH = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] skid_data;
    logic skid_valid;
    logic next_skid_valid;
    logic push;
    logic pop;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_skid_valid = skid_valid;
        if (!out_valid || pop) begin
            next_skid_valid = 1'b0;
        end else if (push) begin
            next_skid_valid = 1'b1;
        end
    end

    // ************************************************************
    // Two entries: output stage plus skid stage
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
            skid_valid <= 1'b0;
            skid_data <= '0;
            in_ready <= 1'b0;
        end else begin
            skid_valid <= next_skid_valid;
            in_ready <= !next_skid_valid;
            if (!out_valid || pop) begin
                if (skid_valid) begin
                    out_data <= skid_data;
                    out_valid <= 1'b1;
                end else begin
                    out_data <= in_data;
                    out_valid <= push;
                end
            end else if (push) begin
                skid_data <= in_data;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    held_data_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("Buffer dropped a stalled word");
endmodule
